//--- include/spm_pkg.sv
// package for the serial port mode select block: modes, codes, timing counts
// assumes a 100 MHz core clock
`default_nettype none
package spm_pkg;
   // operating modes decided at start-up
   typedef enum logic [1:0] {SPM_MODE_RESERVED, SPM_MODE_TEST, SPM_MODE_CONFIG, SPM_MODE_DATA} spm_mode_t;
   // physical line variants
   typedef enum logic [1:0] {SPM_PHY_SE_FULL, SPM_PHY_DIFF_FULL, SPM_PHY_DIFF_HALF} spm_phy_t;
   localparam logic [3:0] SPM_POS_RESERVED = 4'hD;
   localparam logic [3:0] SPM_POS_TEST = 4'hE;
   localparam logic [3:0] SPM_POS_CONFIG = 4'hF;
   localparam logic [3:0] SPM_POS_DATA_MAX = 4'hB;
   localparam int SPM_CLK_HZ = 100000000;
   localparam int SPM_CFG_BAUD = 9600;
   localparam int SPM_STOP_BITS = 1;
   localparam int SPM_DATA_BITS = 8;
   localparam int SPM_BIT_CYC = SPM_CLK_HZ / SPM_CFG_BAUD;
   localparam logic [15:0] SPM_BIT_CYC_W = 16'(SPM_BIT_CYC);
   localparam logic [15:0] SPM_HALF_CYC_W = 16'(SPM_BIT_CYC / 2);
   // blink half period in ms
   localparam int SPM_BLINK_MS = 250;
   localparam int SPM_BLINK_CYC = (SPM_CLK_HZ / 1000) * SPM_BLINK_MS;
   localparam logic [3:0] SPM_FRAME_BITS = 4'(1 + SPM_DATA_BITS + SPM_STOP_BITS);
   localparam logic [1:0] SPM_STARTUP_CYC = 2'h3;
endpackage : spm_pkg
`default_nettype wire

//--- rtl/spm_bit_timer.sv
// bit-rate enable generator for the configuration serial port
// assumes one core clock; restart clears phase
`timescale 1ns/1ps
`default_nettype none
module spm_bit_timer
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic restart,
   input wire logic [15:0] load_val,
   output logic tick
);
   import spm_pkg::*;
   logic [15:0] cnt_q;
   // down counter, one-cycle tick at zero then reload
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         cnt_q <= load_val;
         tick <= 1'b0;
      end
      else if (cnt_q == 16'h0000)
      begin
         cnt_q <= SPM_BIT_CYC_W - 16'h0001;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q - 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : spm_bit_timer
`default_nettype wire

//--- rtl/spm_mode_select.sv
// start-up mode decode and configuration-mode serial port
// assumes selector and rx pins are asynchronous; phy_sel is static from same-clock logic
// What this block does
// [RULE_01] at start-up read both selectors, decode reserved, test, config, data modes
// [RULE_02] config mode only when both selectors read F, held until next start
// [RULE_03] config mode uses 9600 baud, eight data, no parity, one stop bit
// [RULE_04] red serial-status lamp blinks continuously while config mode is active
// [RULE_05] test and config modes allowed only with single-ended full-duplex line
// [RULE_06] data mode exposes the selector positions to the application
// [RULE_07] port runs single-ended full duplex, differential full or half duplex
// [RULE_08] any other selector combination is reserved and leaves the port inactive
`timescale 1ns/1ps
`default_nettype none
module spm_mode_select
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [3:0] mode_selector_a,
   input wire logic [3:0] mode_selector_b,
   input wire spm_pkg::spm_phy_t phy_sel,
   input wire logic rx_pin,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic tx_pin,
   output logic tx_se_en,
   output logic tx_diff_en,
   output logic rx_diff_en,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output spm_pkg::spm_mode_t mode,
   output logic mode_valid,
   output logic cfg_active,
   output logic [3:0] app_param_a,
   output logic [3:0] app_param_b,
   output logic led_red
);
   import spm_pkg::*;
   logic [3:0] sa_m_q, sa_q, sb_m_q, sb_q;
   logic rx_m_q, rx_s_q;
   logic [1:0] start_q;
   spm_mode_t mode_d;
   logic port_on;
   logic [26:0] blink_q;
   logic tx_busy_q;
   logic [9:0] tx_sh_q;
   logic [3:0] tx_n_q;
   logic tx_tick, tx_go;
   // pin synchronisers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sa_m_q <= 4'h0;
         sa_q <= 4'h0;
         sb_m_q <= 4'h0;
         sb_q <= 4'h0;
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end
      else
      begin
         sa_m_q <= mode_selector_a;
         sa_q <= sa_m_q;
         sb_m_q <= mode_selector_b;
         sb_q <= sb_m_q;
         rx_m_q <= rx_pin;
         rx_s_q <= rx_m_q;
      end
   end
   // mode decode of synchronised selectors
   always_comb
   begin
      // [RULE_01] decode operating mode
      if (sa_q == SPM_POS_RESERVED && sb_q == SPM_POS_RESERVED)
         mode_d = SPM_MODE_RESERVED;
      // [RULE_05] single-ended only
      else if (sa_q == SPM_POS_TEST && sb_q == SPM_POS_TEST)
         mode_d = (phy_sel == SPM_PHY_SE_FULL) ? SPM_MODE_TEST : SPM_MODE_RESERVED;
      // [RULE_02] both at F
      else if (sa_q == SPM_POS_CONFIG && sb_q == SPM_POS_CONFIG)
         mode_d = (phy_sel == SPM_PHY_SE_FULL) ? SPM_MODE_CONFIG : SPM_MODE_RESERVED;
      else if (sa_q <= SPM_POS_DATA_MAX && sb_q <= SPM_POS_DATA_MAX)
         mode_d = SPM_MODE_DATA;
      // [RULE_08] everything else reserved
      else
         mode_d = SPM_MODE_RESERVED;
   end
   // [RULE_02] latch decision once after sync settles
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         start_q <= 2'h0;
         mode <= SPM_MODE_RESERVED;
         mode_valid <= 1'b0;
         cfg_active <= 1'b0;
         app_param_a <= 4'h0;
         app_param_b <= 4'h0;
      end
      else if (start_q != SPM_STARTUP_CYC)
      begin
         start_q <= start_q + 2'h1;
         if (start_q == SPM_STARTUP_CYC - 2'h1)
         begin
            mode <= mode_d;
            mode_valid <= 1'b1;
            cfg_active <= (mode_d == SPM_MODE_CONFIG);
            // [RULE_06] expose positions in data mode
            app_param_a <= (mode_d == SPM_MODE_DATA) ? sa_q : 4'h0;
            app_param_b <= (mode_d == SPM_MODE_DATA) ? sb_q : 4'h0;
         end
      end
   end
   // [RULE_08] port inactive in reserved mode or before decision
   assign port_on = mode_valid && (mode != SPM_MODE_RESERVED);
   // [RULE_07] line driver enables by variant
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_se_en <= 1'b0;
         tx_diff_en <= 1'b0;
         rx_diff_en <= 1'b0;
      end
      else
      begin
         tx_se_en <= port_on && phy_sel == SPM_PHY_SE_FULL;
         tx_diff_en <= port_on && (phy_sel == SPM_PHY_DIFF_FULL || (phy_sel == SPM_PHY_DIFF_HALF && tx_busy_q));
         rx_diff_en <= port_on && (phy_sel == SPM_PHY_DIFF_FULL || (phy_sel == SPM_PHY_DIFF_HALF && !tx_busy_q));
      end
   end
   // [RULE_04] red blink counter while config active
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         blink_q <= 27'h0000000;
         led_red <= 1'b0;
      end
      else if (!cfg_active)
      begin
         blink_q <= 27'h0000000;
         led_red <= 1'b0;
      end
      else if (blink_q == 27'(SPM_BLINK_CYC - 1))
      begin
         blink_q <= 27'h0000000;
         led_red <= ~led_red;
      end
      else
         blink_q <= blink_q + 27'h0000001;
   end
   // transmitter, 8N1 at the configuration rate
   assign tx_go = cfg_active && tx_ready && tx_valid;
   spm_bit_timer u_tx_timer
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .restart(tx_go),
      .load_val(SPM_BIT_CYC_W - 16'h0002), // restart and tick register add two cycles to the start bit
      .tick(tx_tick)
   );
   // [RULE_03] frame: start, 8 data lsb first, stop
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_busy_q <= 1'b0;
         tx_sh_q <= 10'h3FF;
         tx_n_q <= 4'h0;
         tx_pin <= 1'b1;
         tx_ready <= 1'b0;
      end
      else if (tx_go)
      begin
         tx_busy_q <= 1'b1;
         tx_ready <= 1'b0;
         tx_sh_q <= {1'b1, tx_data, 1'b0};
         tx_n_q <= 4'h0;
         tx_pin <= 1'b0;
      end
      else if (tx_busy_q && tx_tick)
      begin
         if (tx_n_q == SPM_FRAME_BITS - 4'h1)
         begin
            tx_busy_q <= 1'b0;
            tx_ready <= 1'b1;
            tx_pin <= 1'b1;
         end
         else
         begin
            tx_n_q <= tx_n_q + 4'h1;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_pin <= tx_sh_q[1];
         end
      end
      else if (!tx_busy_q)
         tx_ready <= cfg_active;
   end
   // receiver, samples mid-bit
   logic rx_busy_q, rx_tick, rx_go;
   logic [3:0] rx_n_q;
   logic [7:0] rx_sh_q;
   assign rx_go = cfg_active && !rx_busy_q && !rx_s_q;
   spm_bit_timer u_rx_timer
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .restart(rx_go),
      .load_val(SPM_HALF_CYC_W),
      .tick(rx_tick)
   );
   // [RULE_03] receive 8N1, drop frame on bad start or stop
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_busy_q <= 1'b0;
         rx_n_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (rx_go)
         begin
            rx_busy_q <= 1'b1;
            rx_n_q <= 4'h0;
         end
         else if (rx_busy_q && rx_tick)
         begin
            rx_n_q <= rx_n_q + 4'h1;
            if (rx_n_q == 4'h0 && rx_s_q)
               rx_busy_q <= 1'b0; // false start
            else if (rx_n_q == SPM_FRAME_BITS - 4'h1)
            begin
               rx_busy_q <= 1'b0;
               rx_valid <= rx_s_q;
               if (rx_s_q)
                  rx_data <= rx_sh_q;
            end
            else if (rx_n_q != 4'h0)
               rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
         end
      end
   end
   // [RULE_02] mode held after decision
   chk_mode_held: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_02]
      $past(mode_valid) |-> $stable(mode)) else $error("mode changed after start-up");
   // [RULE_05] config needs single-ended line
   chk_cfg_se_only: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_05]
      $rose(mode_valid) && phy_sel != SPM_PHY_SE_FULL |-> mode != SPM_MODE_CONFIG && mode != SPM_MODE_TEST)
      else $error("test or config mode on differential line");
   // [RULE_04] lamp off outside config
   chk_led_off: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_04]
      !cfg_active |=> !led_red) else $error("lamp lit outside config mode");
   // [RULE_04] blink counter advances in config
   chk_blink_run: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_04]
      cfg_active && blink_q != 27'(SPM_BLINK_CYC - 1) |=> blink_q == $past(blink_q) + 27'h0000001)
      else $error("blink counter stalled in config mode");
   // [RULE_08] reserved keeps port quiet
   chk_reserved_idle: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_08]
      mode == SPM_MODE_RESERVED |=> !tx_se_en && !tx_diff_en && tx_pin) else $error("port active in reserved mode");
   // [RULE_06] params zero unless data mode
   chk_param_zero: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_06]
      mode_valid && mode != SPM_MODE_DATA |-> app_param_a == 4'h0 && app_param_b == 4'h0)
      else $error("selector params exposed outside data mode");
   // [RULE_03] start bit low for at least eight cycles
   sequence s_tx_start;
      tx_go ##1 !tx_pin;
   endsequence
   chk_tx_start: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_03]
      s_tx_start |-> !tx_pin [*8]) else $error("start bit too short");
   // [RULE_01] config decode latched from both F
   chk_cfg_decode: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_01]
      $rose(mode_valid) && mode == SPM_MODE_CONFIG |-> $past(sa_q) == SPM_POS_CONFIG && $past(sb_q) == SPM_POS_CONFIG)
      else $error("config mode without both selectors at F");
   // [RULE_07] half duplex never enables both directions
   chk_half_dir: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_07]
      phy_sel == SPM_PHY_DIFF_HALF |-> !(tx_diff_en && rx_diff_en)) else $error("half duplex both directions on");
endmodule : spm_mode_select
`default_nettype wire

//--- verification/spm_far_end.sv
// far-side serial party: sends and hears 8N1 frames at the config baud
// assumes a 100 MHz core clock; line idles at mark (high)
`timescale 1ns/1ps
`default_nettype none
module spm_far_end
(
   input wire logic core_clk,
   input wire logic line_in,
   output logic line_out,
   output logic [7:0] heard,
   output logic heard_ok
);
   localparam int BIT_CYC = 100000000 / 9600;
   // idle line and empty capture
   initial
   begin
      line_out = 1'b1;
      heard = 8'h00;
      heard_ok = 1'b0;
   end
   // start bit, eight data lsb first, one stop
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_out = fr[i];
         repeat (BIT_CYC) @(negedge core_clk);
      end
   endtask : send
   // mid-bit sampling of what the port sends
   always
   begin
      @(negedge line_in);
      heard_ok = 1'b0;
      repeat (BIT_CYC / 2) @(negedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(negedge core_clk);
         heard[i] = line_in;
      end
      repeat (BIT_CYC) @(negedge core_clk);
      heard_ok = line_in;
   end
endmodule : spm_far_end
`default_nettype wire

//--- verification/tb_top.sv
// bench for the mode select block: start-up decode cases, then one config-mode byte each way
// assumes the far-side model in spm_far_end; inputs change on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spm_pkg::*;
   localparam int BIT_CYC = 100000000 / 9600;
   logic core_clk, resetn, rx_pin, tx_valid, tx_ready, tx_pin, tx_se_en, tx_diff_en, rx_diff_en;
   logic rx_valid, mode_valid, cfg_active, led_red, heard_ok;
   logic [3:0] mode_selector_a, mode_selector_b, app_param_a, app_param_b;
   logic [7:0] tx_data, rx_data, heard, tx_b, rx_b;
   spm_phy_t phy_sel;
   spm_mode_t mode;
   int bad_count, checked, cycles, n;
   int ca[9] = '{13, 14, 14, 15, 15, 12, 3, 0, 15};
   int cb[9] = '{13, 14, 14, 15, 12, 12, 10, 0, 15};
   int cp[9] = '{0, 0, 1, 2, 0, 0, 1, 2, 0};
   logic [7:0] exp_q[$];
   spm_mode_select spm_mode_select_i (.core_clk(core_clk), .resetn(resetn), .mode_selector_a(mode_selector_a),
      .mode_selector_b(mode_selector_b), .phy_sel(phy_sel), .rx_pin(rx_pin), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .tx_pin(tx_pin), .tx_se_en(tx_se_en), .tx_diff_en(tx_diff_en),
      .rx_diff_en(rx_diff_en), .rx_valid(rx_valid), .rx_data(rx_data), .mode(mode), .mode_valid(mode_valid),
      .cfg_active(cfg_active), .app_param_a(app_param_a), .app_param_b(app_param_b), .led_red(led_red));
   spm_far_end spm_far_end_i (.core_clk(core_clk), .line_in(tx_pin), .line_out(rx_pin), .heard(heard),
      .heard_ok(heard_ok));
   // clock and hang limit
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 106000) // nine short cases plus one 104160-cycle frame
      begin
         bad_count++;
         wrap_up();
      end
   end
   // reference decode of the two selectors
   function automatic int exp_mode(int a, int b, int p);
      if (a == 13 && b == 13) return 0;
      if (a == 14 && b == 14) return (p == 0) ? 1 : 0;
      if (a == 15 && b == 15) return (p == 0) ? 2 : 0;
      if (a <= 11 && b <= 11) return 3;
      return 0;
   endfunction : exp_mode
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // restart with given selectors and line variant, then check the decision
   task automatic run_case(input int a, input int b, input int p);
      int em;
      logic [2:0] en;
      em = exp_mode(a, b, p);
      en = (em == 0) ? 3'h0 : (p == 0) ? 3'h4 : (p == 1) ? 3'h3 : 3'h1;
      resetn = 1'b0;
      mode_selector_a = 4'(a);
      mode_selector_b = 4'(b);
      phy_sel = spm_phy_t'(p);
      tx_valid = (em != 2); // a request outside config mode must be ignored
      repeat (3) @(negedge core_clk);
      resetn = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("mode_valid early", 16'h0, 16'(mode_valid));
      @(negedge core_clk);
      chk("mode_valid", 16'h1, 16'(mode_valid));
      chk("mode", 16'(em), 16'(mode));
      chk("cfg_active", 16'(em == 2), 16'(cfg_active));
      chk("app params", (em == 3) ? 16'({a[3:0], b[3:0]}) : 16'h0, 16'({app_param_a, app_param_b}));
      @(negedge core_clk);
      chk("tx_ready", 16'(em == 2), 16'(tx_ready));
      chk("tx_pin idle", 16'h1, 16'(tx_pin));
      chk("led_red", 16'h0, 16'(led_red));
      chk("enables", 16'(en), 16'({tx_se_en, tx_diff_en, rx_diff_en}));
      // drop the request a step before the next case raises it again
      tx_valid = 1'b0;
      mode_selector_a = 4'($urandom_range(15));
      mode_selector_b = 4'($urandom_range(15));
      repeat (4) @(negedge core_clk);
      chk("mode held", 16'(em), 16'(mode));
      $display("case %0h/%0h phy %0d done", a, b, p);
   endtask : run_case
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // main sequence
   initial
   begin
      core_clk = 1'b0;
      resetn = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      mode_selector_a = 4'h0;
      mode_selector_b = 4'h0;
      phy_sel = SPM_PHY_SE_FULL;
      void'($urandom(32'h5198));
      ca[7] = $urandom_range(11);
      cb[7] = $urandom_range(11);
      @(negedge core_clk);
      for (int i = 0; i < 9; i++)
         run_case(ca[i], cb[i], cp[i]);
      tx_b = 8'($urandom_range(255));
      rx_b = 8'($urandom_range(255));
      // reference model: bytes expected at the port, then at the far end
      exp_q.push_back(rx_b);
      exp_q.push_back(tx_b);
      tx_data = tx_b;
      tx_valid = 1'b1;
      @(negedge core_clk);
      tx_valid = 1'b0;
      chk("tx start", 16'h0, 16'({tx_ready, tx_pin}));
      fork
         spm_far_end_i.send(rx_b);
         for (n = 0; n < 12 * BIT_CYC && rx_valid !== 1'b1; n++) @(negedge core_clk);
      join
      chk("rx_data", 16'(exp_q.pop_front()), 16'(rx_data));
      for (n = 0; n < 2 * BIT_CYC && tx_ready !== 1'b1; n++) @(negedge core_clk);
      chk("tx_ready again", 16'h1, 16'(tx_ready));
      chk("heard byte", 16'(exp_q.pop_front()), 16'(heard));
      chk("stop bit", 16'h1, 16'(heard_ok));
      $display("config byte exchange done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
